// ---- bcf_pkg.sv ----
package bcf_pkg;

  // ****************************************
  // Addresses and fields
  // ****************************************
  localparam logic [7:0] BCF_BCAST_ADDR = 8'h00;
  localparam logic [15:0] BCF_REG_RUN = 16'h0001;
  localparam logic [15:0] BCF_REG_SPEED = 16'h0002;
  localparam logic [15:0] BCF_IMM_HI = 16'h001F;
  localparam int BCF_BIT_RUN = 0;
  localparam int BCF_BIT_DIR = 1;
  localparam int BCF_BIT_EXTF = 4;
  localparam int BCF_BIT_FRST = 5;
  localparam int BCF_BIT_MFDI = 12;
  localparam logic [15:0] BCF_SPEED_FULL = 16'h7530;
  localparam logic [15:0] BCF_RST_SPEED = 16'h0000;
  localparam logic [15:0] BCF_CODE_NONE = 16'h0000;

  // ****************************************
  // Fault codes
  // ****************************************
  localparam logic [15:0] BCF_C_UV_MAIN = 16'h0002;
  localparam logic [15:0] BCF_C_UV_CTRL = 16'h0003;
  localparam logic [15:0] BCF_C_UV_SOFT = 16'h0004;
  localparam logic [15:0] BCF_C_HOT = 16'h0009;
  localparam logic [15:0] BCF_C_HOT_ALT = 16'h000A;
  localparam logic [15:0] BCF_C_OVERTORQUE = 16'h000D;
  localparam logic [15:0] BCF_C_EXT_T3 = 16'h0011;
  localparam logic [15:0] BCF_C_EXT_T1 = 16'h0042;
  localparam logic [15:0] BCF_C_EXT_T2 = 16'h0043;
  localparam logic [15:0] BCF_C_SERIAL = 16'h0021;
  localparam logic [15:0] BCF_C_OPT_COMM = 16'h0022;
  localparam logic [15:0] BCF_C_IN_PHASE = 16'h001B;
  localparam logic [15:0] BCF_C_OUT_PHASE = 16'h001C;
  localparam logic [15:0] BCF_C_NVM_WRITE = 16'h001F;
  localparam logic [15:0] BCF_C_SEARCH = 16'h003B;
  localparam logic [15:0] BCF_C_VOUT = 16'h004D;
  localparam logic [15:0] BCF_C_NODE = 16'h0052;
  localparam logic [15:0] BCF_C_HW = 16'h0030;
  localparam logic [15:0] BCF_C_CONV = 16'h0083;
  localparam logic [15:0] BCF_C_FLASH = 16'h008D;
  localparam logic [15:0] BCF_C_PWM_REG = 16'h009C;
  localparam logic [15:0] BCF_C_OPT_INCOMP = 16'h0101;
  localparam logic [15:0] BCF_C_OPT_UNSEAT = 16'h0102;
  localparam logic [15:0] BCF_C_OPT_CRC = 16'h0113;
  localparam logic [15:0] BCF_C_OPT_FRAME = 16'h0114;
  localparam logic [15:0] BCF_C_OPT_ABORT = 16'h0115;
  localparam logic [15:0] BCF_C_CLK_NOTSET = 16'h0401;
  localparam logic [15:0] BCF_C_CLK_INTERVAL = 16'h0404;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] slave;
    logic [15:0] addr;
    logic [15:0] data;
  } bcf_wr_t;

  typedef struct packed {
    logic run;
    logic reverse;
    logic ext_fault;
    logic fault_reset;
    logic [2:0] input_terminal;
    logic [15:0] speed;
  } bcf_cmd_t;

  typedef struct packed {
    logic main_circuit_undervoltage;
    logic control_supply_undervoltage;
    logic soft_charge_fault;
    logic heatsink_too_hot;
    logic heatsink_too_hot_alt;
    logic overtorque_one;
    logic [4:0] ext_trip_terminal;
    logic ext_trip_terminal_one;
    logic ext_trip_terminal_two;
    logic serial_link_error;
    logic option_link_error;
    logic input_phase_missing;
    logic output_phase_missing;
    logic nvm_write_fault;
    logic speed_search_retry_limit;
    logic output_voltage_check_fault;
    logic node_setup_fault;
    logic board_conversion_fault;
    logic flash_circuit_fault;
    logic pwm_setting_reg_fault;
    logic option_incompatible;
    logic option_unseated;
    logic option_rx_crc_at_drive;
    logic option_rx_frame_at_drive;
    logic option_rx_abort_at_drive;
    logic clock_not_set;
    logic clock_interval_fault;
    logic other_hw_fault;
  } bcf_fault_t;

endpackage : bcf_pkg

// ---- bcf_broadcast_fault_map.sv ----
`timescale 1ns/100ps
module bcf_broadcast_fault_map
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Own node address
  input wire logic [7:0] node_addr,
  // Decoded write from the frame parser
  input wire logic wr_valid,
  input wire bcf_pkg::bcf_wr_t wr,
  // Fault sources, same clock
  input wire bcf_pkg::bcf_fault_t faults,
  // Drive command
  output logic [15:0] ctrl_word,
  output bcf_pkg::bcf_cmd_t cmd,
  output logic cmd_update,
  output logic speed_over_range,
  // Reply control
  output logic resp_req,
  output logic resp_quiet,
  // Fault reporting
  output logic [15:0] fault_code,
  output logic [15:0] fault_hist,
  output logic fault_active,
  output logic [1:0] comm_err_hold
);
  import bcf_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] ctrl;
    bcf_cmd_t cmd;
    logic cmd_update;
    logic over_range;
    logic resp_req;
    logic resp_quiet;
    logic [15:0] code;
    logic [15:0] hist;
    logic active;
    logic [1:0] comm;
  } bcf_state_t;

  bcf_state_t st_ff;
  bcf_state_t nxt_st;

  // ****************************************
  // Fault priority encoder
  // ****************************************
  function automatic logic [15:0] bcf_encode(input bcf_fault_t f);
    logic [15:0] c;
    c = BCF_CODE_NONE;
    if (f.main_circuit_undervoltage)
      c = BCF_C_UV_MAIN;
    else if (f.control_supply_undervoltage)
      c = BCF_C_UV_CTRL;
    else if (f.soft_charge_fault)
      c = BCF_C_UV_SOFT;
    else if (f.heatsink_too_hot)
      c = BCF_C_HOT;
    else if (f.heatsink_too_hot_alt)
      c = BCF_C_HOT_ALT;
    else if (f.overtorque_one)
      c = BCF_C_OVERTORQUE;
    else if (f.ext_trip_terminal[0])
      c = BCF_C_EXT_T3;
    else if (f.ext_trip_terminal[1])
      c = BCF_C_EXT_T3 + 16'h0001;
    else if (f.ext_trip_terminal[2])
      c = BCF_C_EXT_T3 + 16'h0002;
    else if (f.ext_trip_terminal[3])
      c = BCF_C_EXT_T3 + 16'h0003;
    else if (f.ext_trip_terminal[4])
      c = BCF_C_EXT_T3 + 16'h0004;
    else if (f.ext_trip_terminal_one)
      c = BCF_C_EXT_T1;
    else if (f.ext_trip_terminal_two)
      c = BCF_C_EXT_T2;
    else if (f.serial_link_error)
      c = BCF_C_SERIAL;
    else if (f.option_link_error)
      c = BCF_C_OPT_COMM;
    else if (f.input_phase_missing)
      c = BCF_C_IN_PHASE;
    else if (f.output_phase_missing)
      c = BCF_C_OUT_PHASE;
    else if (f.nvm_write_fault)
      c = BCF_C_NVM_WRITE;
    else if (f.speed_search_retry_limit)
      c = BCF_C_SEARCH;
    else if (f.output_voltage_check_fault)
      c = BCF_C_VOUT;
    else if (f.node_setup_fault)
      c = BCF_C_NODE;
    else if (f.board_conversion_fault)
      c = BCF_C_CONV;
    else if (f.flash_circuit_fault)
      c = BCF_C_FLASH;
    else if (f.pwm_setting_reg_fault)
      c = BCF_C_PWM_REG;
    else if (f.option_incompatible)
      c = BCF_C_OPT_INCOMP;
    else if (f.option_unseated)
      c = BCF_C_OPT_UNSEAT;
    else if (f.option_rx_crc_at_drive)
      c = BCF_C_OPT_CRC;
    else if (f.option_rx_frame_at_drive)
      c = BCF_C_OPT_FRAME;
    else if (f.option_rx_abort_at_drive)
      c = BCF_C_OPT_ABORT;
    else if (f.clock_not_set)
      c = BCF_C_CLK_NOTSET;
    else if (f.clock_interval_fault)
      c = BCF_C_CLK_INTERVAL;
    else if (f.other_hw_fault)
      c = BCF_C_HW;
    return c;
  endfunction : bcf_encode

  // ****************************************
  // Request decode
  // ****************************************
  logic is_bcast;
  logic is_mine;
  logic in_imm;
  logic wr_run;
  logic wr_speed;
  logic frst_rise;
  logic [15:0] new_code;

  // Address match and register select
  always_comb
  begin
    is_bcast = (wr.slave == BCF_BCAST_ADDR);
    is_mine = wr_valid && (is_bcast || wr.slave == node_addr);
    in_imm = (wr.addr <= BCF_IMM_HI);
    wr_run = is_mine && wr.addr == BCF_REG_RUN;
    wr_speed = is_mine && wr.addr == BCF_REG_SPEED;
    frst_rise = wr_run && wr.data[BCF_BIT_FRST] && !st_ff.cmd.fault_reset;
    new_code = bcf_encode(faults);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.cmd_update = 1'b0;
    nxt_st.resp_req = 1'b0;
    nxt_st.resp_quiet = 1'b0;
    // Control word, applied at once, all 16 bits kept in ctrl
    if (wr_run)
    begin
      nxt_st.ctrl = wr.data;
      nxt_st.cmd.run = wr.data[BCF_BIT_RUN];
      nxt_st.cmd.reverse = wr.data[BCF_BIT_DIR];
      nxt_st.cmd.ext_fault = wr.data[BCF_BIT_EXTF];
      nxt_st.cmd.fault_reset = wr.data[BCF_BIT_FRST];
      nxt_st.cmd.input_terminal = wr.data[BCF_BIT_MFDI +: 3];
      nxt_st.cmd_update = 1'b1;
    end
    // Speed reference clamped to full scale
    if (wr_speed)
    begin
      nxt_st.over_range = (wr.data > BCF_SPEED_FULL);
      nxt_st.cmd.speed = nxt_st.over_range ? BCF_SPEED_FULL : wr.data;
      nxt_st.cmd_update = 1'b1;
    end
    // Answer only writes addressed to this node alone
    if (is_mine && in_imm)
    begin
      nxt_st.resp_req = !is_bcast;
      nxt_st.resp_quiet = is_bcast;
    end
    // Fault reset clears the held trace and link errors
    if (frst_rise)
    begin
      nxt_st.active = 1'b0;
      nxt_st.code = BCF_CODE_NONE;
      nxt_st.comm = 2'b00;
    end
    // Link errors held until reset; a new error wins over the clear
    if (faults.serial_link_error)
      nxt_st.comm[0] = 1'b1;
    if (faults.option_link_error)
      nxt_st.comm[1] = 1'b1;
    // First fault is latched; older code moves to history
    if (new_code != BCF_CODE_NONE && (!st_ff.active || frst_rise))
    begin
      nxt_st.active = 1'b1;
      nxt_st.code = new_code;
      if (st_ff.code != BCF_CODE_NONE)
        nxt_st.hist = st_ff.code;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff <= '0;
      st_ff.cmd.speed <= BCF_RST_SPEED;
    end
    else
      st_ff <= nxt_st;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign ctrl_word = st_ff.ctrl;
  assign cmd = st_ff.cmd;
  assign cmd_update = st_ff.cmd_update;
  assign speed_over_range = st_ff.over_range;
  assign resp_req = st_ff.resp_req;
  assign resp_quiet = st_ff.resp_quiet;
  assign fault_code = st_ff.code;
  assign fault_hist = st_ff.hist;
  assign fault_active = st_ff.active;
  assign comm_err_hold = st_ff.comm;

endmodule : bcf_broadcast_fault_map

// ---- bcf_broadcast_fault_map_checker.sv ----
`timescale 1ns/100ps
module bcf_broadcast_fault_map_checker
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Inputs
  input wire logic [7:0] node_addr,
  input wire logic wr_valid,
  input wire bcf_pkg::bcf_wr_t wr,
  input wire bcf_pkg::bcf_fault_t faults,
  // Outputs
  input wire logic [15:0] ctrl_word,
  input wire bcf_pkg::bcf_cmd_t cmd,
  input wire logic cmd_update,
  input wire logic speed_over_range,
  input wire logic resp_req,
  input wire logic resp_quiet,
  input wire logic [15:0] fault_code,
  input wire logic [15:0] fault_hist,
  input wire logic fault_active,
  input wire logic [1:0] comm_err_hold
);
  import bcf_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic mine;
  // Write aimed at this node or at every node
  assign mine = wr_valid && (wr.slave == 8'h00 || wr.slave == node_addr);
  a_bcast_quiet: assert property (mine && wr.slave == 8'h00 && wr.addr <= 16'h001F
    |=> resp_quiet && !resp_req) else $error("broadcast write answered");
  a_unicast_reply: assert property (mine && wr.slave != 8'h00 && wr.addr <= 16'h001F
    |=> resp_req && !resp_quiet) else $error("addressed write not answered");
  a_foreign_ignored: assert property (wr_valid && wr.slave != 8'h00 && !mine
    |=> !resp_req && !resp_quiet && !cmd_update) else $error("foreign write taken");
  a_high_silent: assert property (mine && wr.addr > 16'h001F
    |=> !resp_req && !resp_quiet) else $error("pulse for high address");
  a_ctrl_bits: assert property (mine && wr.addr == 16'h0001 |=> cmd_update
    && {cmd.reverse, cmd.run, cmd.fault_reset, cmd.ext_fault} ==
    {$past(wr.data[1:0]), $past(wr.data[5:4])}) else $error("control bits wrong");
  a_terminals: assert property (mine && wr.addr == 16'h0001
    |=> cmd.input_terminal == $past(wr.data[14:12])) else $error("terminal bits wrong");
  a_speed_scale: assert property (mine && wr.addr == 16'h0002 |=> cmd.speed ==
    ($past(wr.data) > 16'h7530 ? 16'h7530 : $past(wr.data))) else $error("speed wrong");
  a_fault_latch: assert property (!fault_active && faults != '0 && !wr_valid
    |=> fault_active && fault_code != 16'h0000) else $error("fault not latched");
  a_overtorque: assert property (!fault_active && faults[31:26] == 6'h01 && !wr_valid
    |=> fault_code == 16'h000D) else $error("overtorque code wrong");
  a_trace_keep: assert property (fault_active && !wr_valid
    |=> fault_active && $stable(fault_code)) else $error("trace changed");
  a_serial_hold: assert property (faults.serial_link_error |=> comm_err_hold[0])
    else $error("serial error not held");
  a_comm_sticky: assert property (comm_err_hold != 2'b00 && !wr_valid
    |=> (comm_err_hold & $past(comm_err_hold)) == $past(comm_err_hold))
    else $error("comm error lost");
  c_bcast: cover property (mine && wr.slave == 8'h00);
  c_fault: cover property ($rose(fault_active));
  c_clamp: cover property (speed_over_range);
endmodule : bcf_broadcast_fault_map_checker

// ---- bcf_master_model.sv ----
`timescale 1ns/100ps
module bcf_master_model
(
  // Clock
  input wire logic clk_sys,
  // Decoded write
  output logic wr_valid,
  output bcf_pkg::bcf_wr_t wr
);
  import bcf_pkg::*;
  // Idle bus
  initial
  begin
    wr_valid = 1'b0;
    wr = '0;
  end
  // One write held over one edge; no reply awaited
  task automatic send(input logic [7:0] slave, input logic [15:0] addr,
                      input logic [15:0] data);
    @(posedge clk_sys);
    #1;
    wr_valid = 1'b1;
    wr = '{slave, addr, data};
    @(posedge clk_sys);
    #1;
    wr_valid = 1'b0;
    wr = ~wr; // Released bus shows junk
  endtask : send
endmodule : bcf_master_model

// ---- bcf_broadcast_fault_map_test.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module bcf_broadcast_fault_map_test;
  import bcf_pkg::*;
  logic clk_sys;
  logic resetn;
  logic [7:0] node_addr;
  logic wr_valid;
  bcf_wr_t wr;
  bcf_fault_t faults;
  logic [15:0] ctrl_word;
  bcf_cmd_t cmd;
  logic cmd_update;
  logic speed_over_range;
  logic resp_req;
  logic resp_quiet;
  logic [15:0] fault_code;
  logic [15:0] fault_hist;
  logic fault_active;
  logic [1:0] comm_err_hold;
  int errors;
  int n_checks;
  // Trace code for each fault bit, bit 31 first
  logic [15:0] codes [31:0] = '{16'h0002, 16'h0003, 16'h0004, 16'h0009, 16'h000A,
    16'h000D, 16'h0015, 16'h0014, 16'h0013, 16'h0012, 16'h0011, 16'h0042, 16'h0043,
    16'h0021, 16'h0022, 16'h001B, 16'h001C, 16'h001F, 16'h003B, 16'h004D, 16'h0052,
    16'h0083, 16'h008D, 16'h009C, 16'h0101, 16'h0102, 16'h0113, 16'h0114, 16'h0115,
    16'h0401, 16'h0404, 16'h0030};
  bcf_broadcast_fault_map uut (.clk_sys(clk_sys), .resetn(resetn), .node_addr(node_addr),
    .wr_valid(wr_valid), .wr(wr), .faults(faults), .ctrl_word(ctrl_word), .cmd(cmd),
    .cmd_update(cmd_update), .speed_over_range(speed_over_range), .resp_req(resp_req),
    .resp_quiet(resp_quiet), .fault_code(fault_code), .fault_hist(fault_hist),
    .fault_active(fault_active), .comm_err_hold(comm_err_hold));
  bcf_master_model m (.clk_sys(clk_sys), .wr_valid(wr_valid), .wr(wr));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask : step
  task automatic put(input logic [7:0] s, input logic [15:0] a, input logic [15:0] d,
                     input logic q, input logic r);
    m.send(s, a, d);
    `CHK(resp_quiet, q)
    `CHK(resp_req, r)
  endtask : put
  task automatic clear;
    put(8'h00, 16'h0001, 16'h0020, 1'b1, 1'b0);
    put(8'h00, 16'h0001, 16'h0000, 1'b1, 1'b0);
  endtask : clear
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_bcast;
    put(8'h00, 16'h0001, 16'hFFFF, 1'b1, 1'b0);
    `CHK({cmd.run, cmd.reverse, cmd.ext_fault, cmd.fault_reset}, 4'hF)
    `CHK(cmd.input_terminal, 3'h7)
    `CHK(cmd_update, 1'b1)
    `CHK(ctrl_word, 16'hFFFF)
    put(8'h00, 16'h0001, 16'h4001, 1'b1, 1'b0);
    `CHK({cmd.run, cmd.reverse, cmd.ext_fault, cmd.fault_reset}, 4'h8)
    `CHK(cmd.input_terminal, 3'h4)
    step;
    `CHK(cmd_update, 1'b0)
  endtask : t_bcast
  task automatic t_unicast;
    put(8'h05, 16'h0001, 16'h0002, 1'b0, 1'b1);
    `CHK({cmd.run, cmd.reverse}, 2'b01)
    put(8'h07, 16'h0001, 16'h0001, 1'b0, 1'b0);
    `CHK(cmd.run, 1'b0)
    put(8'h05, 16'h0003, 16'h1234, 1'b0, 1'b1);
    `CHK(cmd_update, 1'b0)
    put(8'h00, 16'h0100, 16'h0001, 1'b0, 1'b0);
    `CHK(cmd.run, 1'b0)
  endtask : t_unicast
  task automatic t_speed;
    logic [15:0] d [4] = '{16'h7530, 16'h7531, 16'hFFFF, 16'h3A98};
    foreach (d[i])
    begin
      put(8'h00, 16'h0002, d[i], 1'b1, 1'b0);
      `CHK(cmd.speed, (d[i] > 16'h7530) ? 16'h7530 : d[i])
      `CHK(speed_over_range, d[i] > 16'h7530)
    end
  endtask : t_speed
  task automatic t_faults;
    for (int i = 31; i >= 0; i--)
    begin
      faults = bcf_fault_t'(32'h1 << i);
      step;
      `CHK(fault_code, codes[i])
      `CHK(fault_code, codes[i])
      faults = '0;
      step;
      `CHK(comm_err_hold, {i == 17, i == 18})
      clear;
      `CHK({fault_active, comm_err_hold}, 3'b000)
    end
  endtask : t_faults
  task automatic t_priority;
    faults = bcf_fault_t'(32'h8000_0001);
    step;
    `CHK(fault_code, 16'h0002)
    faults = bcf_fault_t'(32'h0400_0000);
    step;
    `CHK(fault_code, 16'h0002)
    put(8'h00, 16'h0001, 16'h0020, 1'b1, 1'b0);
    `CHK({fault_code, fault_hist}, 32'h000D_0002)
    faults = '0;
    put(8'h00, 16'h0001, 16'h0000, 1'b1, 1'b0);
    clear;
  endtask : t_priority
  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    errors++;
    conclude();
  end
  initial
  begin
    resetn = 1'b0;
    node_addr = 8'h05;
    faults = '0;
    errors = 0;
    n_checks = 0;
    repeat (16) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    step;
    `CHK({cmd_update, resp_req, resp_quiet, fault_active}, 4'h0)
    t_bcast;
    t_unicast;
    t_speed;
    t_faults;
    t_priority;
    conclude();
  end
endmodule : bcf_broadcast_fault_map_test
bind bcf_broadcast_fault_map bcf_broadcast_fault_map_checker chk (.clk_sys(clk_sys),
  .resetn(resetn), .node_addr(node_addr), .wr_valid(wr_valid), .wr(wr), .faults(faults),
  .ctrl_word(ctrl_word), .cmd(cmd), .cmd_update(cmd_update),
  .speed_over_range(speed_over_range), .resp_req(resp_req), .resp_quiet(resp_quiet),
  .fault_code(fault_code), .fault_hist(fault_hist), .fault_active(fault_active),
  .comm_err_hold(comm_err_hold));
